// ==== testbench/relay_parameter_access_bench.sv ====
// self-checking bench for the parameter access block
`timescale 1ns/1ps
`default_nettype none
module relay_parameter_access_bench;
   import rpa_pkg::*;
   localparam logic [10:0] PAT = 11'h555;
   logic clk_sys, reset, supply_lost_pin, reg_clear, ok, vld;
   logic panel_ack, gate_open, gate_locked;
   logic [79:0] meas_current;
   logic [2:0] ctrl_in_pin;
   logic [10:0] stage_state;
   logic [15:0] q;
   logic [63:0] setting_out;
   rpa_req_s bus_req;
   rpa_resp_s bus_resp;
   rpa_panel_s panel_req;
   int fail_count, n_compared, cyc;
   rpa_top i_dut(.clk_sys, .reset, .meas_current, .ctrl_in_pin,
      .stage_state, .supply_lost_pin, .reg_clear, .bus_req, .bus_resp,
      .panel_req, .panel_ack, .setting_out, .gate_open, .gate_locked);
   rpa_master i_master(.clk_sys, .bus_req, .bus_resp);
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   //==================================================================
   // tasks
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task acc(input logic w, input logic [7:0] c, input logic [15:0] d,
      input logic eok, input logic [15:0] eq);
      i_master.xfer(w, c, d, ok, vld, q);
      chk("resp valid", 16'h0001, {15'h0, vld});
      chk("resp ok", {15'h0, eok}, {15'h0, ok});
      if (!w && eok) chk("read data", eq, q);
   endtask
   task pnl(input logic p, input logic [7:0] i, input logic [15:0] d,
      input logic ea);
      @(posedge clk_sys);
      panel_req <= '{1'b1, p, i, d};
      @(posedge clk_sys);
      // released panel lines show inverted data, never a stale copy
      panel_req <= '{1'b0, ~p, ~i, ~d};
      @(posedge clk_sys);
      chk("panel ack", {15'h0, ea}, {15'h0, panel_ack});
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      // whole run needs well under a thousand cycles
      if (cyc == 5000) begin
         fail_count++;
         wrap_up;
      end
   end
   //==================================================================
   // tests
   initial begin
      reset = 1;
      supply_lost_pin = 0;
      reg_clear = 0;
      meas_current = '0;
      ctrl_in_pin = '0;
      stage_state = '0;
      panel_req = '0;
      cyc = 0;
      repeat (16) @(posedge clk_sys);
      reset <= 0;
      for (int k = 0; k < 4; k++) begin
         acc(0, RPA_CODE_SET_BASE + 8'(k), 0, 1, RPA_SET_MIN[k]);
      end
      chk("setting", RPA_SET_MIN[2], setting_out[47:32]);
      chk("setting", RPA_SET_MIN[3], setting_out[63:48]);
      acc(0, RPA_CODE_PW_OPEN, 0, 1, 0);
      acc(1, RPA_CODE_SET_BASE, 16'h0014, 0, 0);
      acc(1, RPA_CODE_CURR_BASE, 16'h0001, 0, 0);
      acc(0, 8'h50, 0, 0, 0);
      chk("setting", 16'h0005, setting_out[15:0]);
      $display("test closed gate done");
      acc(1, RPA_CODE_PW_OPEN, 16'h0001, 1, 0);
      acc(1, RPA_CODE_SET_BASE, 16'h0033, 0, 0);
      acc(1, RPA_CODE_SET_BASE, 16'h0032, 1, 0);
      acc(1, RPA_CODE_SET_BASE, 16'h0004, 0, 0);
      acc(0, RPA_CODE_SET_BASE, 0, 1, 16'h0032);
      acc(1, RPA_CODE_PW_CLOSE, 16'h03e8, 0, 0);
      acc(1, RPA_CODE_PW_CLOSE, 16'h0007, 1, 0);
      chk("gate open", 1, {15'h0, gate_open});
      acc(1, RPA_CODE_PW_CLOSE, 16'h0007, 1, 0);
      chk("gate open", 0, {15'h0, gate_open});
      acc(1, RPA_CODE_PW_OPEN, 16'h0001, 0, 0);
      acc(1, RPA_CODE_PW_OPEN, 16'h0007, 1, 0);
      $display("test password done");
      @(posedge clk_sys);
      meas_current <= {16'h0104, 16'h0103, 16'h0102, 16'h0101, 16'h0100};
      ctrl_in_pin <= 3'b101;
      stage_state <= PAT;
      supply_lost_pin <= 1;
      repeat (4) @(posedge clk_sys);
      chk("gate open", 0, {15'h0, gate_open});
      supply_lost_pin <= 0;
      for (int k = 0; k < 5; k++) begin
         acc(0, RPA_CODE_CURR_BASE + 8'(k), 0, 1, 16'h0100 + 16'(k));
      end
      for (int k = 0; k < 3; k++) begin
         acc(0, 8'h05 + 8'(k), 0, 1, {15'h0, ctrl_in_pin[k]});
      end
      for (int k = 0; k < 11; k++) begin
         acc(0, 8'h10 + 8'(k), 0, 1, {15'h0, PAT[k]});
      end
      stage_state <= '0;
      for (int k = 0; k < 11; k++) begin
         acc(0, 8'h20 + 8'(k), 0, 1, {15'h0, PAT[k]});
      end
      acc(0, RPA_CODE_STATE_BASE, 0, 1, 0);
      reg_clear <= 1;
      @(posedge clk_sys);
      reg_clear <= 0;
      for (int k = 0; k < 11; k++) acc(0, 8'h20 + 8'(k), 0, 1, 0);
      stage_state <= 11'h002;
      @(posedge clk_sys);
      stage_state <= '0;
      acc(0, 8'h21, 0, 1, 1);
      $display("test readback done");
      repeat (7) acc(1, RPA_CODE_PW_OPEN, 16'h0002, 0, 0);
      chk("locked", 1, {15'h0, gate_locked});
      acc(1, RPA_CODE_PW_OPEN, 16'h0000, 0, 0);
      acc(1, RPA_CODE_PW_OPEN, 16'h0007, 0, 0);
      pnl(1, 0, 16'h0000, 0);
      chk("locked", 1, {15'h0, gate_locked});
      pnl(1, 0, 16'h0009, 1);
      chk("locked", 0, {15'h0, gate_locked});
      acc(1, RPA_CODE_PW_OPEN, 16'h0009, 1, 0);
      pnl(0, 1, 16'h0009, 0);
      pnl(0, 1, 16'h0008, 1);
      chk("setting", 16'h0008, setting_out[31:16]);
      $display("test lock and panel done");
      wrap_up;
   end
endmodule
`default_nettype wire

// ==== testbench/rpa_master.sv ====
// serial master model, one request at a time
`timescale 1ns/1ps
`default_nettype none
module rpa_master
   import rpa_pkg::*;
(
   input wire logic clk_sys,
   output rpa_req_s bus_req,
   input wire rpa_resp_s bus_resp
);
   initial bus_req = '0;
   task automatic xfer(input logic w, input logic [7:0] c,
      input logic [15:0] d, output logic ok, output logic v,
      output logic [15:0] q);
      @(posedge clk_sys);
      bus_req <= '{1'b1, w, c, d};
      @(posedge clk_sys);
      // released lines show inverted data, never a stale copy
      bus_req <= '{1'b0, 1'b0, ~c, ~d};
      @(posedge clk_sys);
      // answer registered at the taking edge, still standing here
      v = bus_resp.valid;
      ok = bus_resp.ok;
      q = bus_resp.data;
   endtask
endmodule
`default_nettype wire

// ==== testbench/rpa_top_props.sv ====
// port assertions for the parameter access block
`timescale 1ns/1ps
`default_nettype none
module rpa_props
   import rpa_pkg::*;
#(
   parameter int N_SET = RPA_N_SET
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [RPA_N_CURR*16-1:0] meas_current,
   input wire logic [RPA_N_IN-1:0] ctrl_in_pin,
   input wire logic [RPA_N_STAGE-1:0] stage_state,
   input wire logic supply_lost_pin,
   input wire logic reg_clear,
   input wire rpa_req_s bus_req,
   input wire rpa_resp_s bus_resp,
   input wire rpa_panel_s panel_req,
   input wire logic panel_ack,
   input wire logic [N_SET*16-1:0] setting_out,
   input wire logic gate_open,
   input wire logic gate_locked
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   //==================================================================
   // request steps
   sequence s_req;
      bus_req.valid;
   endsequence
   sequence s_open;
      bus_req.valid && bus_req.write && bus_req.code == RPA_CODE_PW_OPEN;
   endsequence
   //==================================================================
   // checks
   a_resp_follows: assert property (s_req |=> bus_resp.valid)
      else $error("request got no answer");
   a_resp_stray: assert property (!bus_req.valid |=> !bus_resp.valid)
      else $error("answer without request");
   a_closed_refused: assert property (s_req and bus_req.write &&
      bus_req.code == RPA_CODE_SET_BASE && !gate_open |=> !bus_resp.ok)
      else $error("protected write accepted while closed");
   a_open_ok: assert property (s_open ##1 bus_resp.ok |-> gate_open)
      else $error("accepted open left gate closed");
   a_open_cause: assert property ($rose(gate_open) |->
      $past(bus_req.valid) && $past(bus_req.code) == RPA_CODE_PW_OPEN)
      else $error("gate opened without open request");
   a_lock_shut: assert property (gate_locked |-> !gate_open)
      else $error("gate open while locked");
   a_lock_keeps: assert property (gate_locked |=>
      gate_locked || $past(panel_req.valid))
      else $error("lock released without panel write");
   a_lock_cause: assert property ($rose(gate_locked) |->
      $past(bus_req.valid) && $past(bus_req.code) == RPA_CODE_PW_OPEN)
      else $error("lock without open attempt");
   a_supply_close: assert property ((supply_lost_pin &&
      !bus_req.valid) [*3] |=> !gate_open)
      else $error("gate open after supply loss");
   a_set_cause: assert property ($changed(setting_out) |->
      $past(bus_req.valid && bus_req.write) || $past(panel_req.valid))
      else $error("setting changed with no write");
   a_panel_ack: assert property (panel_ack |-> $past(panel_req.valid))
      else $error("panel ack without request");
endmodule
bind rpa_top rpa_props #(.N_SET(N_SET)) i_props(.clk_sys, .reset,
   .meas_current, .ctrl_in_pin, .stage_state, .supply_lost_pin,
   .reg_clear, .bus_req, .bus_resp, .panel_req, .panel_ack,
   .setting_out, .gate_open, .gate_locked);
`default_nettype wire

// ==== verilog/rpa_pkg.sv ====
// constants, codes and carriers for the relay parameter access block
//=====================================================================
package rpa_pkg;
   //==================================================================
   // parameter codes
   localparam logic [7:0] RPA_CODE_CURR_BASE = 8'h00;
   localparam logic [7:0] RPA_CODE_IN_BASE = 8'h05;
   localparam logic [7:0] RPA_CODE_STATE_BASE = 8'h10;
   localparam logic [7:0] RPA_CODE_REC_BASE = 8'h20;
   localparam logic [7:0] RPA_CODE_SET_BASE = 8'h30;
   localparam logic [7:0] RPA_CODE_PW_OPEN = 8'h40;
   localparam logic [7:0] RPA_CODE_PW_CLOSE = 8'h41;
   localparam int RPA_N_CURR = 5;
   localparam int RPA_N_IN = 3;
   localparam int RPA_N_STAGE = 11;
   localparam int RPA_N_SET = 4;
   //==================================================================
   // password figures
   localparam logic [15:0] RPA_PW_MIN = 16'h0001;
   localparam logic [15:0] RPA_PW_MAX = 16'h03e7;
   localparam logic [15:0] RPA_PW_DEFAULT = 16'h0001;
   localparam logic [15:0] RPA_PW_LOCKED = 16'h0000;
   localparam logic [2:0] RPA_WRONG_LIMIT = 3'h7;
   //==================================================================
   // settings in tenths: low oc start, low ef start, unbalance %, time
   localparam logic [15:0] RPA_SET_MIN [RPA_N_SET] =
      '{16'h0005, 16'h0001, 16'h000a, 16'h0001};
   localparam logic [15:0] RPA_SET_MAX [RPA_N_SET] =
      '{16'h0032, 16'h0008, 16'h0064, 16'h012c};
   //==================================================================
   // carriers
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
      logic [15:0] data;
   } rpa_req_s;
   typedef struct packed {
      logic valid;
      logic ok;
      logic [15:0] data;
   } rpa_resp_s;
   typedef struct packed {
      logic valid;
      logic pw_write;
      logic [7:0] index;
      logic [15:0] data;
   } rpa_panel_s;
   typedef enum logic [1:0] {
      RPA_GATE_CLOSED = 2'b00,
      RPA_GATE_OPEN = 2'b01,
      RPA_GATE_LOCKED = 2'b10
   } rpa_gate_e;
endpackage

// ==== verilog/rpa_top.sv ====
// serial parameter access: readback, settings, password gate
`timescale 1ns/1ps
`default_nettype none
module rpa_top
   import rpa_pkg::*;
#(
   parameter int N_SET = RPA_N_SET
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [RPA_N_CURR*16-1:0] meas_current,
   input wire logic [RPA_N_IN-1:0] ctrl_in_pin,
   input wire logic [RPA_N_STAGE-1:0] stage_state,
   input wire logic supply_lost_pin,
   input wire logic reg_clear,
   input wire rpa_req_s bus_req,
   output rpa_resp_s bus_resp,
   input wire rpa_panel_s panel_req,
   output logic panel_ack,
   output logic [N_SET*16-1:0] setting_out,
   output logic gate_open,
   output logic gate_locked
);
   //==================================================================
   // input synchronisers
   logic [RPA_N_IN-1:0] ctrl_s1_r;
   logic [RPA_N_IN-1:0] ctrl_s2_r;
   logic supply_s1_r;
   logic supply_s2_r;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_s1_r <= '0;
         ctrl_s2_r <= '0;
         supply_s1_r <= 1'b0;
         supply_s2_r <= 1'b0;
      end else begin
         ctrl_s1_r <= ctrl_in_pin;
         ctrl_s2_r <= ctrl_s1_r;
         supply_s1_r <= supply_lost_pin;
         supply_s2_r <= supply_s1_r;
      end
   end

   //==================================================================
   // stage state and recorded bits
   logic [RPA_N_STAGE-1:0] state_r;
   logic [RPA_N_STAGE-1:0] state_nxt;
   logic [RPA_N_STAGE-1:0] rec_r;
   logic [RPA_N_STAGE-1:0] rec_nxt;

   always_comb begin
      state_nxt = stage_state;
      // an activation in the clear cycle still records
      if (reg_clear) begin
         rec_nxt = stage_state;
      end else begin
         rec_nxt = rec_r | stage_state;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_r <= '0;
         rec_r <= '0;
      end else begin
         state_r <= state_nxt;
         rec_r <= rec_nxt;
      end
   end

   //==================================================================
   // settings, password and gate
   logic [15:0] setting_r [N_SET];
   logic [15:0] setting_nxt [N_SET];
   logic [15:0] pw_r;
   logic [15:0] pw_nxt;
   rpa_gate_e gate_r;
   rpa_gate_e gate_nxt;
   logic [2:0] wrong_r;
   logic [2:0] wrong_nxt;
   rpa_resp_s resp_r;
   rpa_resp_s resp_nxt;
   logic panel_ack_r;
   logic panel_ack_nxt;

   function automatic logic in_range(input logic [15:0] v,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   logic [7:0] set_idx;
   logic [7:0] rd_idx;
   logic set_hit;
   logic pw_ok;
   logic [15:0] rd_data;
   logic rd_ok;

   always_comb begin
      set_idx = bus_req.code - RPA_CODE_SET_BASE;
      set_hit = (bus_req.code >= RPA_CODE_SET_BASE) &&
                (set_idx < 8'(N_SET));
      pw_ok = in_range(bus_req.data, RPA_PW_MIN, RPA_PW_MAX);
   end

   // read mux
   always_comb begin
      rd_data = 16'h0000;
      rd_ok = 1'b1;
      rd_idx = 8'h00;
      if (bus_req.code < RPA_CODE_IN_BASE) begin
         rd_idx = bus_req.code - RPA_CODE_CURR_BASE;
         rd_data = meas_current[rd_idx[2:0]*16 +: 16];
      end else if (bus_req.code < RPA_CODE_IN_BASE + 8'(RPA_N_IN)) begin
         rd_idx = bus_req.code - RPA_CODE_IN_BASE;
         rd_data = {15'h0000, ctrl_s2_r[rd_idx[1:0]]};
      end else if ((bus_req.code >= RPA_CODE_STATE_BASE) &&
                   (bus_req.code < RPA_CODE_STATE_BASE +
                    8'(RPA_N_STAGE))) begin
         rd_idx = bus_req.code - RPA_CODE_STATE_BASE;
         rd_data = {15'h0000, state_r[rd_idx[3:0]]};
      end else if ((bus_req.code >= RPA_CODE_REC_BASE) &&
                   (bus_req.code < RPA_CODE_REC_BASE +
                    8'(RPA_N_STAGE))) begin
         rd_idx = bus_req.code - RPA_CODE_REC_BASE;
         rd_data = {15'h0000, rec_r[rd_idx[3:0]]};
      end else if (set_hit) begin
         rd_data = setting_r[set_idx[1:0]];
      end else if ((bus_req.code == RPA_CODE_PW_OPEN) ||
                   (bus_req.code == RPA_CODE_PW_CLOSE)) begin
         // the password itself is never read back
         rd_data = 16'h0000;
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_comb begin
      for (int i = 0; i < N_SET; i++) begin
         setting_nxt[i] = setting_r[i];
      end
      pw_nxt = pw_r;
      gate_nxt = gate_r;
      wrong_nxt = wrong_r;
      resp_nxt = '0;
      panel_ack_nxt = 1'b0;

      // serial bus request
      if (bus_req.valid) begin
         resp_nxt.valid = 1'b1;
         resp_nxt.data = 16'h0000;
         if (!bus_req.write) begin
            resp_nxt.ok = rd_ok;
            resp_nxt.data = rd_data;
         end else if (bus_req.code == RPA_CODE_PW_OPEN) begin
            if (gate_r == RPA_GATE_LOCKED) begin
               resp_nxt.ok = 1'b0;
            end else if (bus_req.data == pw_r) begin
               gate_nxt = RPA_GATE_OPEN;
               wrong_nxt = 3'h0;
               resp_nxt.ok = 1'b1;
            end else if (wrong_r == RPA_WRONG_LIMIT - 3'h1) begin
               pw_nxt = RPA_PW_LOCKED;
               gate_nxt = RPA_GATE_LOCKED;
               wrong_nxt = RPA_WRONG_LIMIT;
               resp_nxt.ok = 1'b0;
            end else begin
               wrong_nxt = wrong_r + 3'h1;
               resp_nxt.ok = 1'b0;
            end
         end else if (bus_req.code == RPA_CODE_PW_CLOSE) begin
            if (gate_r != RPA_GATE_OPEN) begin
               resp_nxt.ok = 1'b0;
            end else if (bus_req.data == pw_r) begin
               gate_nxt = RPA_GATE_CLOSED;
               resp_nxt.ok = 1'b1;
            end else if (pw_ok) begin
               // new password, gate stays open until closed with it
               pw_nxt = bus_req.data;
               resp_nxt.ok = 1'b1;
            end else begin
               resp_nxt.ok = 1'b0;
            end
         end else if (set_hit) begin
            if (gate_r != RPA_GATE_OPEN) begin
               resp_nxt.ok = 1'b0;
            end else if (in_range(bus_req.data,
                                  RPA_SET_MIN[set_idx[1:0]],
                                  RPA_SET_MAX[set_idx[1:0]])) begin
               setting_nxt[set_idx[1:0]] = bus_req.data;
               resp_nxt.ok = 1'b1;
            end else begin
               resp_nxt.ok = 1'b0;
            end
         end else begin
            resp_nxt.ok = 1'b0;
         end
      end

      // front panel, applied after the bus so the panel wins a tie
      if (panel_req.valid) begin
         if (panel_req.pw_write) begin
            if (in_range(panel_req.data, RPA_PW_MIN, RPA_PW_MAX)) begin
               pw_nxt = panel_req.data;
               wrong_nxt = 3'h0;
               if (gate_r == RPA_GATE_LOCKED) begin
                  gate_nxt = RPA_GATE_CLOSED;
               end
               panel_ack_nxt = 1'b1;
            end
         end else if (panel_req.index < 8'(N_SET)) begin
            if (in_range(panel_req.data,
                         RPA_SET_MIN[panel_req.index[1:0]],
                         RPA_SET_MAX[panel_req.index[1:0]])) begin
               setting_nxt[panel_req.index[1:0]] = panel_req.data;
               panel_ack_nxt = 1'b1;
            end
         end
      end

      // supply loss always closes, lock survives
      if (supply_s2_r && (gate_nxt == RPA_GATE_OPEN)) begin
         gate_nxt = RPA_GATE_CLOSED;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < N_SET; i++) begin
            setting_r[i] <= RPA_SET_MIN[i];
         end
         pw_r <= RPA_PW_DEFAULT;
         gate_r <= RPA_GATE_CLOSED;
         wrong_r <= 3'h0;
         resp_r <= '0;
         panel_ack_r <= 1'b0;
      end else begin
         for (int i = 0; i < N_SET; i++) begin
            setting_r[i] <= setting_nxt[i];
         end
         pw_r <= pw_nxt;
         gate_r <= gate_nxt;
         wrong_r <= wrong_nxt;
         resp_r <= resp_nxt;
         panel_ack_r <= panel_ack_nxt;
      end
   end

   //==================================================================
   // outputs
   genvar g;
   generate
      for (g = 0; g < N_SET; g++) begin : g_set
         assign setting_out[g*16 +: 16] = setting_r[g];
      end
   endgenerate

   assign bus_resp = resp_r;
   assign panel_ack = panel_ack_r;
   assign gate_open = (gate_r == RPA_GATE_OPEN);
   assign gate_locked = (gate_r == RPA_GATE_LOCKED);
endmodule
`default_nettype wire
